/* common/tmms_consts.svh */
// Purpose: Constants for the thermal monitor and analog mux select block
// Assumes: 40 MHz core clock
// Notes:   Times kept in their own units, cycle counts derived
`ifndef TMMS_CONSTS_SVH
`define TMMS_CONSTS_SVH

`define TMMS_CLK_MHZ          40
`define TMMS_NUM_WARN         6
`define TMMS_NUM_SENSORS      8
`define TMMS_WARN_80C         8'h50
`define TMMS_WARN_95C         8'h5F
`define TMMS_WARN_110C        8'h6E
`define TMMS_WARN_125C        8'h7D
`define TMMS_WARN_140C        8'h8C
`define TMMS_WARN_155C        8'h9B
`define TMMS_SD_165C          8'hA5
`define TMMS_WARN_HYS_C       8'h05
`define TMMS_SD_HYS_C         8'h0F
`define TMMS_DEBOUNCE_US      10
`define TMMS_DEBOUNCE_CYC     (`TMMS_DEBOUNCE_US * `TMMS_CLK_MHZ)
`define TMMS_WINDOW_US        450
`define TMMS_WINDOW_CYC       (`TMMS_WINDOW_US * `TMMS_CLK_MHZ)
`define TMMS_INTERVAL_US      3000
`define TMMS_INTERVAL_CYC     (`TMMS_INTERVAL_US * `TMMS_CLK_MHZ)

`define TMMS_SEL_OFF          5'h00
`define TMMS_SEL_INPUT        5'h01
`define TMMS_SEL_BACKUP       5'h02
`define TMMS_SEL_COIN         5'h03
`define TMMS_SEL_BUCK1        5'h04
`define TMMS_SEL_BUCK2        5'h05
`define TMMS_SEL_BUCK5        5'h08
`define TMMS_SEL_BUCK6        5'h09
`define TMMS_SEL_BUCK7        5'h0A
`define TMMS_SEL_LDO1         5'h0B
`define TMMS_SEL_LDO2         5'h0C
`define TMMS_SEL_LDO3         5'h0D
`define TMMS_SEL_TEMP_CENTRE  5'h0F
`define TMMS_SEL_TEMP_BUCK1   5'h10
`define TMMS_SEL_TEMP_BUCK2   5'h11
`define TMMS_SEL_TEMP_BUCK5   5'h14
`define TMMS_SEL_TEMP_BUCK6   5'h15
`define TMMS_SEL_TEMP_BUCK7   5'h16
`define TMMS_SEL_TEMP_LDO12   5'h17
`define TMMS_SEL_TEMP_LDO3    5'h18

`endif

/* common/tmms_pkg.sv */
// Purpose: Types for the thermal monitor and analog mux select block
// Assumes: Constants come from tmms_consts.svh
// Notes:   None
package tmms_pkg;
  // Monitor power sequencer states
  typedef enum logic [1:0] {
    TMMS_MON_OFF   = 2'b00,
    TMMS_MON_ON    = 2'b01,
    TMMS_MON_SLEEP = 2'b11
  } tmms_mon_state_t;

  // Routed analog source
  typedef enum logic [4:0] {
    TMMS_SRC_NONE        = 5'h00,
    TMMS_SRC_INPUT       = 5'h01,
    TMMS_SRC_BACKUP      = 5'h02,
    TMMS_SRC_COIN        = 5'h03,
    TMMS_SRC_BUCK1       = 5'h04,
    TMMS_SRC_BUCK2       = 5'h05,
    TMMS_SRC_BUCK5       = 5'h06,
    TMMS_SRC_BUCK6       = 5'h07,
    TMMS_SRC_BUCK7       = 5'h08,
    TMMS_SRC_LDO1        = 5'h09,
    TMMS_SRC_LDO2        = 5'h0A,
    TMMS_SRC_LDO3        = 5'h0B,
    TMMS_SRC_TEMP_CENTRE = 5'h0C,
    TMMS_SRC_TEMP_BUCK1  = 5'h0D,
    TMMS_SRC_TEMP_BUCK2  = 5'h0E,
    TMMS_SRC_TEMP_BUCK5  = 5'h0F,
    TMMS_SRC_TEMP_BUCK6  = 5'h10,
    TMMS_SRC_TEMP_BUCK7  = 5'h11,
    TMMS_SRC_TEMP_LDO12  = 5'h12,
    TMMS_SRC_TEMP_LDO3   = 5'h13
  } tmms_src_t;
endpackage

/* hdl/tmms_debounce.sv */
// Purpose: Debounces one comparator level in both directions
// Assumes: Input already synchronous to core_clk
// Notes:   Count clears to zero while sample_en is low
`timescale 1ns/10ps
`default_nettype none
`include "tmms_consts.svh"

module tmms_debounce (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic sample_en,
  input  wire logic raw_level,
  output logic      stable_level
);
  localparam int unsigned DB_CYC = `TMMS_DEBOUNCE_CYC;

  logic        level_reg;
  logic        level_next;
  logic [8:0]  count_reg;
  logic [8:0]  count_next;

  always_comb begin
    level_next = level_reg;
    count_next = count_reg;
    if (!sample_en) begin
      count_next = 9'h000;
    end else if (raw_level == level_reg) begin
      count_next = 9'h000;
    end else if (count_reg == 9'(DB_CYC - 1)) begin
      level_next = raw_level;
      count_next = 9'h000;
    end else begin
      count_next = count_reg + 9'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      level_reg <= 1'b0;
      count_reg <= 9'h000;
    end else begin
      level_reg <= level_next;
      count_reg <= count_next;
    end
  end

  assign stable_level = level_reg;
endmodule // tmms_debounce
`default_nettype wire

/* hdl/tmms_top.sv */
// Purpose: Thermal warning and shutdown logic plus analog mux select
// Assumes: Temperatures arrive as unsigned degrees C from an ADC
// Notes:   Control bits are plain ports, already on core_clk
`timescale 1ns/10ps
`default_nettype none
`include "tmms_consts.svh"

module tmms_top (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  die_centre_temp,
  input  wire logic [7:0]  observe_temp [8],
  input  wire logic        system_on,
  input  wire logic        standby,
  input  wire logic        temp_monitor_enable,
  input  wire logic        temp_monitor_always_on,
  input  wire logic [5:0]  thermal_warn_mask,
  input  wire logic [5:0]  thermal_warn_clear,
  input  wire logic        analog_mux_enable,
  input  wire logic [4:0]  analog_mux_channel_select,
  output logic             monitor_power,
  output logic [5:0]       thermal_threshold_sense,
  output logic [5:0]       thermal_warn_irq_flag,
  output logic             thermal_shutdown,
  output logic             interrupt_out_n,
  output logic             analog_mux_active,
  output logic             analog_mux_pulldown,
  output logic             analog_mux_reserved,
  output logic [4:0]       analog_mux_source,
  output logic [7:0]       selected_sensor_temp
);
  localparam int unsigned WIN_CYC = `TMMS_WINDOW_CYC;
  localparam int unsigned INT_CYC = `TMMS_INTERVAL_CYC;

  // Selector decode, shared by routing and reserved flag
  function automatic tmms_pkg::tmms_src_t tmms_decode(input logic [4:0] sel);
    tmms_pkg::tmms_src_t src;
    src = tmms_pkg::TMMS_SRC_NONE;
    unique case (sel)
      `TMMS_SEL_INPUT:       src = tmms_pkg::TMMS_SRC_INPUT;
      `TMMS_SEL_BACKUP:      src = tmms_pkg::TMMS_SRC_BACKUP;
      `TMMS_SEL_COIN:        src = tmms_pkg::TMMS_SRC_COIN;
      `TMMS_SEL_BUCK1:       src = tmms_pkg::TMMS_SRC_BUCK1;
      `TMMS_SEL_BUCK2:       src = tmms_pkg::TMMS_SRC_BUCK2;
      `TMMS_SEL_BUCK5:       src = tmms_pkg::TMMS_SRC_BUCK5;
      `TMMS_SEL_BUCK6:       src = tmms_pkg::TMMS_SRC_BUCK6;
      `TMMS_SEL_BUCK7:       src = tmms_pkg::TMMS_SRC_BUCK7;
      `TMMS_SEL_LDO1:        src = tmms_pkg::TMMS_SRC_LDO1;
      `TMMS_SEL_LDO2:        src = tmms_pkg::TMMS_SRC_LDO2;
      `TMMS_SEL_LDO3:        src = tmms_pkg::TMMS_SRC_LDO3;
      `TMMS_SEL_TEMP_CENTRE: src = tmms_pkg::TMMS_SRC_TEMP_CENTRE;
      `TMMS_SEL_TEMP_BUCK1:  src = tmms_pkg::TMMS_SRC_TEMP_BUCK1;
      `TMMS_SEL_TEMP_BUCK2:  src = tmms_pkg::TMMS_SRC_TEMP_BUCK2;
      `TMMS_SEL_TEMP_BUCK5:  src = tmms_pkg::TMMS_SRC_TEMP_BUCK5;
      `TMMS_SEL_TEMP_BUCK6:  src = tmms_pkg::TMMS_SRC_TEMP_BUCK6;
      `TMMS_SEL_TEMP_BUCK7:  src = tmms_pkg::TMMS_SRC_TEMP_BUCK7;
      `TMMS_SEL_TEMP_LDO12:  src = tmms_pkg::TMMS_SRC_TEMP_LDO12;
      `TMMS_SEL_TEMP_LDO3:   src = tmms_pkg::TMMS_SRC_TEMP_LDO3;
      default:               src = tmms_pkg::TMMS_SRC_NONE;
    endcase
    return src;
  endfunction

  // Sensor index for a temperature source, 8 when not a sensor
  function automatic logic [3:0] tmms_sensor_idx(
    input tmms_pkg::tmms_src_t src);
    logic [3:0] idx;
    idx = 4'h8;
    if (src >= tmms_pkg::TMMS_SRC_TEMP_CENTRE) begin
      idx = 4'(src - tmms_pkg::TMMS_SRC_TEMP_CENTRE);
    end
    return idx;
  endfunction

  localparam logic [7:0] WARN_LEVEL [6] = '{
    `TMMS_WARN_80C, `TMMS_WARN_95C, `TMMS_WARN_110C,
    `TMMS_WARN_125C, `TMMS_WARN_140C, `TMMS_WARN_155C};

  // Monitor power sequencer
  tmms_pkg::tmms_mon_state_t mon_state_reg;
  tmms_pkg::tmms_mon_state_t mon_state_next;
  logic [16:0] phase_reg;
  logic [16:0] phase_next;
  logic        sampling;
  logic        continuous;
  logic        mon_active;

  always_comb begin
    continuous = system_on && !standby && temp_monitor_always_on;
    sampling   = standby || !temp_monitor_always_on;
    mon_state_next = mon_state_reg;
    phase_next     = phase_reg;
    unique case (mon_state_reg)
      tmms_pkg::TMMS_MON_OFF: begin
        phase_next = 17'h00000;
        if (temp_monitor_enable && (system_on || standby)) begin
          mon_state_next = tmms_pkg::TMMS_MON_ON;
        end
      end
      tmms_pkg::TMMS_MON_ON: begin
        phase_next = phase_reg + 17'h00001;
        if (!temp_monitor_enable || !(system_on || standby)) begin
          mon_state_next = tmms_pkg::TMMS_MON_OFF;
        end else if (continuous) begin
          phase_next = 17'h00000;
        end else if (sampling && phase_reg == 17'(WIN_CYC - 1)) begin
          mon_state_next = tmms_pkg::TMMS_MON_SLEEP;
        end
      end
      tmms_pkg::TMMS_MON_SLEEP: begin
        phase_next = phase_reg + 17'h00001;
        if (!temp_monitor_enable || !(system_on || standby)) begin
          mon_state_next = tmms_pkg::TMMS_MON_OFF;
        end else if (continuous || phase_reg == 17'(INT_CYC - 1)) begin
          mon_state_next = tmms_pkg::TMMS_MON_ON;
          phase_next     = 17'h00000;
        end
      end
      default: begin
        mon_state_next = tmms_pkg::TMMS_MON_OFF;
        phase_next     = 17'h00000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mon_state_reg <= tmms_pkg::TMMS_MON_OFF;
      phase_reg     <= 17'h00000;
    end else begin
      mon_state_reg <= mon_state_next;
      phase_reg     <= phase_next;
    end
  end

  assign mon_active = (mon_state_reg == tmms_pkg::TMMS_MON_ON);

  // Comparators with falling hysteresis, centre sensor only
  logic [6:0] cmp_raw;
  logic [6:0] cmp_stable;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (cmp_stable[i]) begin
        cmp_raw[i] = die_centre_temp >
          (WARN_LEVEL[i] - `TMMS_WARN_HYS_C);
      end else begin
        cmp_raw[i] = die_centre_temp >= WARN_LEVEL[i];
      end
    end
    if (cmp_stable[6]) begin
      cmp_raw[6] = die_centre_temp >
        (`TMMS_SD_165C - `TMMS_SD_HYS_C);
    end else begin
      cmp_raw[6] = die_centre_temp >= `TMMS_SD_165C;
    end
  end

  for (genvar g = 0; g < 7; g++) begin : g_db
    tmms_debounce u_db (
      .core_clk     (core_clk),
      .reset        (reset),
      .sample_en    (mon_active),
      .raw_level    (cmp_raw[g]),
      .stable_level (cmp_stable[g])
    );
  end

  // Flags, sense, shutdown and interrupt
  logic [5:0] sense_reg;
  logic [5:0] sense_next;
  logic [5:0] flag_reg;
  logic [5:0] flag_next;
  logic       sd_reg;
  logic       sd_next;
  logic       irq_n_reg;
  logic       irq_n_next;
  logic [5:0] rise;

  always_comb begin
    sense_next = cmp_stable[5:0];
    rise       = cmp_stable[5:0] & ~sense_reg;
    flag_next  = (flag_reg & ~thermal_warn_clear) | rise;
    sd_next    = cmp_stable[6];
    irq_n_next = ~|(flag_next & ~thermal_warn_mask);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sense_reg <= 6'h00;
      flag_reg  <= 6'h00;
      sd_reg    <= 1'b0;
      irq_n_reg <= 1'b1;
    end else begin
      sense_reg <= sense_next;
      flag_reg  <= flag_next;
      sd_reg    <= sd_next;
      irq_n_reg <= irq_n_next;
    end
  end

  // Analog mux select
  tmms_pkg::tmms_src_t src_dec;
  logic [4:0] src_reg;
  logic [4:0] src_next;
  logic       act_reg;
  logic       act_next;
  logic       pd_reg;
  logic       pd_next;
  logic       rsv_reg;
  logic       rsv_next;
  logic [7:0] obs_reg;
  logic [7:0] obs_next;
  logic [3:0] sidx;

  always_comb begin
    src_dec  = tmms_decode(analog_mux_channel_select);
    sidx     = tmms_sensor_idx(src_dec);
    pd_next  = !analog_mux_enable || !system_on;
    act_next = analog_mux_enable && system_on &&
               (src_dec != tmms_pkg::TMMS_SRC_NONE);
    rsv_next = analog_mux_enable &&
               (analog_mux_channel_select != `TMMS_SEL_OFF) &&
               (src_dec == tmms_pkg::TMMS_SRC_NONE);
    src_next = act_next ? 5'(src_dec) : 5'(tmms_pkg::TMMS_SRC_NONE);
    obs_next = (act_next && sidx < 4'h8) ?
               observe_temp[sidx[2:0]] : 8'h00;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_reg <= 5'h00;
      act_reg <= 1'b0;
      pd_reg  <= 1'b1;
      rsv_reg <= 1'b0;
      obs_reg <= 8'h00;
    end else begin
      src_reg <= src_next;
      act_reg <= act_next;
      pd_reg  <= pd_next;
      rsv_reg <= rsv_next;
      obs_reg <= obs_next;
    end
  end

  logic mon_pwr_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mon_pwr_reg <= 1'b0;
    end else begin
      mon_pwr_reg <= (mon_state_next == tmms_pkg::TMMS_MON_ON);
    end
  end

  assign monitor_power           = mon_pwr_reg;
  assign thermal_threshold_sense = sense_reg;
  assign thermal_warn_irq_flag   = flag_reg;
  assign thermal_shutdown        = sd_reg;
  assign interrupt_out_n         = irq_n_reg;
  assign analog_mux_active       = act_reg;
  assign analog_mux_pulldown     = pd_reg;
  assign analog_mux_reserved     = rsv_reg;
  assign analog_mux_source       = src_reg;
  assign selected_sensor_temp    = obs_reg;

  // Assertions
  irq_follows_flag_a: assert property (
    @(posedge core_clk) disable iff (reset)
    ((flag_reg & ~$past(thermal_warn_mask)) != 6'h00) |-> !interrupt_out_n)
    else $error("interrupt not asserted for unmasked flag");

  flag_sticky_a: assert property (
    @(posedge core_clk) disable iff (reset)
    ($past(flag_reg[0]) && !$past(thermal_warn_clear[0])) |-> flag_reg[0])
    else $error("flag dropped without clear");

  sense_held_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (!mon_active && !$past(mon_active)) |=> $stable(sense_reg))
    else $error("sense changed while monitor off");

  mux_pulldown_a: assert property (
    @(posedge core_clk) disable iff (reset)
    !analog_mux_enable |=> (analog_mux_pulldown && !analog_mux_active))
    else $error("mux not pulled down when disabled");

  sel_zero_hiz_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (analog_mux_enable && system_on && analog_mux_channel_select == 5'h00)
    |=> (!analog_mux_active && !analog_mux_pulldown))
    else $error("selector zero not high impedance");

  window_len_a: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(mon_active) && !continuous |-> mon_active[*8])
    else $error("sampling window too short");

  monitor_off_a: assert property (
    @(posedge core_clk) disable iff (reset)
    !temp_monitor_enable |=> !mon_active)
    else $error("monitor active while disabled");

  always_on_a: assert property (
    @(posedge core_clk) disable iff (reset)
    (continuous && temp_monitor_enable && mon_active) |=> mon_active)
    else $error("always-on monitor dropped");

  shutdown_src_a: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(thermal_shutdown) |-> $past(cmp_stable[6]))
    else $error("shutdown without debounced crossing");
endmodule // tmms_top
`default_nettype wire

/* test/tmms_host_model.sv */
// Purpose: Host software stand-in that clears raised warning flags
// Assumes: Clear writes land shortly after a clock edge
// Notes:   Acknowledges only while ack_enable is high
`timescale 1ns/10ps
`default_nettype none

module tmms_host_model (
  input  wire logic       core_clk,
  input  wire logic       ack_enable,
  input  wire logic       interrupt_out_n,
  input  wire logic [5:0] thermal_warn_irq_flag,
  output logic      [5:0] thermal_warn_clear
);
  initial thermal_warn_clear = 6'h00;

  // One-cycle write-one-to-clear of every flag seen set
  always @(posedge core_clk) begin
    #1;
    if (ack_enable && !interrupt_out_n && thermal_warn_clear == 6'h00) begin
      thermal_warn_clear = thermal_warn_irq_flag;
    end else begin
      thermal_warn_clear = 6'h00;
    end
  end
endmodule // tmms_host_model

`default_nettype wire

/* test/tmms_tb_top.sv */
// Purpose: Self-checking bench for thermal warnings and mux select
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Sampling counts are fixed, so sampling runs take 19k cycles
`timescale 1ns/10ps
`default_nettype none

module tmms_tb_top;
  logic       core_clk, reset, system_on, standby, en, aon, ack;
  logic       mux_en, monitor_power, thermal_shutdown, interrupt_out_n;
  logic       analog_mux_active, analog_mux_pulldown, analog_mux_reserved;
  logic [7:0] die_centre_temp, selected_sensor_temp;
  logic [7:0] observe_temp [8];
  logic [5:0] mask, clr, sense, flag;
  logic [4:0] sel, analog_mux_source;
  int         failures, num_checks;

  tmms_top tmms_top_inst (
    .core_clk(core_clk), .reset(reset),
    .die_centre_temp(die_centre_temp), .observe_temp(observe_temp),
    .system_on(system_on), .standby(standby),
    .temp_monitor_enable(en), .temp_monitor_always_on(aon),
    .thermal_warn_mask(mask), .thermal_warn_clear(clr),
    .analog_mux_enable(mux_en), .analog_mux_channel_select(sel),
    .monitor_power(monitor_power), .thermal_threshold_sense(sense),
    .thermal_warn_irq_flag(flag), .thermal_shutdown(thermal_shutdown),
    .interrupt_out_n(interrupt_out_n),
    .analog_mux_active(analog_mux_active),
    .analog_mux_pulldown(analog_mux_pulldown),
    .analog_mux_reserved(analog_mux_reserved),
    .analog_mux_source(analog_mux_source),
    .selected_sensor_temp(selected_sensor_temp));

  tmms_host_model tmms_host_model_inst (
    .core_clk(core_clk), .ack_enable(ack),
    .interrupt_out_n(interrupt_out_n),
    .thermal_warn_irq_flag(flag), .thermal_warn_clear(clr));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset;
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
  endtask

  task automatic heat(input logic [7:0] t, input int n);
    die_centre_temp = t;
    tick(n);
  endtask

  function automatic logic [4:0] exp_src(input logic [4:0] s);
    case (s)
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05: exp_src = s;
      5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D: exp_src = s - 5'h02;
      5'h0F, 5'h10, 5'h11: exp_src = s - 5'h03;
      5'h14, 5'h15, 5'h16, 5'h17, 5'h18: exp_src = s - 5'h05;
      default: exp_src = 5'h00;
    endcase
  endfunction

  task automatic t_reset;
    do_reset;
    check(interrupt_out_n, 8'h01, "irq after reset");
    check(analog_mux_pulldown, 8'h01, "pulldown after reset");
    check(flag, 8'h00, "flags after reset");
    check(monitor_power, 8'h00, "power after reset");
  endtask

  task automatic t_mux;
    logic [4:0] e;
    system_on = 1'b1;
    sel = 5'h0F;
    tick(2);
    check(analog_mux_pulldown, 8'h01, "disabled pulldown");
    check(analog_mux_active, 8'h00, "disabled active");
    mux_en = 1'b1;
    for (int i = 0; i < 32; i++) begin
      sel = i[4:0];
      tick(2);
      e = exp_src(i[4:0]);
      check(analog_mux_source, e, "mux source");
      check(analog_mux_active, e != 5'h00, "mux active");
      check(analog_mux_reserved, e == 5'h00 && i != 0, "reserved");
      check(analog_mux_pulldown, 8'h00, "enabled pulldown");
      check(selected_sensor_temp, e >= 5'h0C ? 8'hC0 + e - 8'h0C : 8'h00,
            "sensor temp");
    end
    system_on = 1'b0;
    sel = 5'h01;
    tick(2);
    check(analog_mux_active, 8'h00, "active outside run");
  endtask

  task automatic t_warn;
    system_on = 1'b1;
    en = 1'b1;
    aon = 1'b1;
    tick(2);
    check(monitor_power, 8'h01, "monitor on");
    heat(8'h4F, 600);
    check(sense, 8'h00, "below lowest");
    check(thermal_shutdown, 8'h00, "side sensors ignored");
    heat(8'h50, 395);
    check(sense, 8'h00, "rise debounce");
    tick(15);
    check(sense, 8'h01, "rise sense");
    check(flag, 8'h01, "rise flag");
    check(interrupt_out_n, 8'h00, "irq low");
    heat(8'h4C, 600);
    check(sense, 8'h01, "hysteresis hold");
    heat(8'h4B, 395);
    check(sense, 8'h01, "fall debounce");
    tick(15);
    check(sense, 8'h00, "fall release");
    check(flag, 8'h01, "flag latched");
    mask = 6'h01;
    tick(2);
    check(interrupt_out_n, 8'h01, "masked irq");
    mask = 6'h00;
    ack = 1'b1;
    tick(6);
    check(flag, 8'h00, "flag cleared");
    check(interrupt_out_n, 8'h01, "irq released");
    ack = 1'b0;
    heat(8'h50, 200);
    heat(8'h40, 600);
    check(sense, 8'h00, "short crossing");
  endtask

  task automatic t_shut;
    heat(8'hA4, 600);
    check(sense, 8'h3F, "all six sensed");
    check(thermal_shutdown, 8'h00, "below shutdown");
    heat(8'hA5, 410);
    check(thermal_shutdown, 8'h01, "shutdown");
    heat(8'h97, 600);
    check(thermal_shutdown, 8'h01, "shutdown hold");
    heat(8'h96, 410);
    check(thermal_shutdown, 8'h00, "shutdown release");
    check(sense, 8'h1F, "highest released");
    check(flag, 8'h3F, "all six flagged");
    check(interrupt_out_n, 8'h00, "warn irq");
    ack = 1'b1;
    tick(6);
    check(flag, 8'h00, "flags cleared");
    ack = 1'b0;
    en = 1'b0;
    tick(3);
    check(monitor_power, 8'h00, "monitor off");
    heat(8'hA0, 600);
    check(sense, 8'h1F, "sense frozen");
    check(flag, 8'h00, "no new flags");
  endtask

  task automatic sample_check;
    en = 1'b1;
    die_centre_temp = 8'h20;
    do_reset;
    tick(100);
    check(monitor_power, 8'h01, "window on");
    tick(17800);
    check(monitor_power, 8'h01, "window late");
    tick(200);
    check(monitor_power, 8'h00, "window over");
    heat(8'hA5, 600);
    check(sense, 8'h00, "asleep no eval");
    die_centre_temp = 8'h20;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up;
  end

  initial begin
    {reset, system_on, standby, en, aon, ack, mux_en} = 7'h00;
    die_centre_temp = 8'h20;
    mask = 6'h00;
    sel = 5'h00;
    for (int i = 0; i < 8; i++) observe_temp[i] = 8'hC0 + i[7:0];
    t_reset;
    t_mux;
    t_warn;
    t_shut;
    system_on = 1'b1;
    aon = 1'b0;
    sample_check;
    system_on = 1'b0;
    standby = 1'b1;
    aon = 1'b1;
    sample_check;
    wrap_up;
  end
endmodule // tmms_tb_top

`default_nettype wire
